// ### include/uapl_pkg.sv
// package: registers, fields, states and rate table of the serial port
package uapl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RATE = 8'h04;
  localparam logic [7:0] OFF_TXD  = 8'h08;
  localparam logic [7:0] OFF_RXD  = 8'h0C;
  localparam logic [7:0] OFF_STS  = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_LINE = 8'h18;
  // control and rate field positions
  localparam int C_CHAR8  = 0;
  localparam int C_PAR    = 1;
  localparam int C_FLOW   = 3;
  localparam int C_ABD    = 5;
  localparam int C_FONT   = 6;
  localparam int C_BELL   = 7;
  localparam int C_LOGOUT = 8;
  localparam int R_BOTH   = 8;
  // status bit positions
  localparam int S_RX   = 0;
  localparam int S_TX   = 1;
  localparam int S_LOST = 2;
  localparam int S_ABD  = 3;
  localparam int NSTS   = 4;
  // bit period counter width
  localparam int CNT_W  = 22;
  // reset values
  localparam logic [3:0] RST_RATE = 4'hD;
  // control characters
  localparam logic [7:0] CH_XON  = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_BELL = 8'h07;
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_CR7E = 8'h8D;

  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ODD = 2'b01,
                            PAR_EVEN = 2'b10} uapl_par_e;
  typedef enum logic [1:0] {FC_NONE = 2'b00, FC_RTS = 2'b01,
                            FC_DTR = 2'b10, FC_XON = 2'b11} uapl_flow_e;
  typedef enum logic [2:0] {T_IDLE = 3'b000, T_START = 3'b001,
                            T_DATA = 3'b010, T_PAR = 3'b011,
                            T_STOP = 3'b100} uapl_tx_e;
  typedef enum logic [2:0] {R_IDLE = 3'b000, R_START = 3'b001,
                            R_DATA = 3'b010, R_PAR = 3'b011,
                            R_STOP = 3'b100, R_MEAS = 3'b101} uapl_rx_e;

  typedef struct packed {logic rxd; logic cts; logic dsr;} uapl_line_in_s;
  typedef struct packed {logic txd; logic rts; logic dtr;} uapl_line_out_s;

  typedef struct packed {
    logic rx_m, rx_s, cts_m, cts_s, dsr_m, dsr_s;
    logic char8; uapl_par_e par; uapl_flow_e flow;
    logic abd, font, bell, logged_in;
    logic [3:0] rx_rate, tx_rate, sts, mask;
    logic dp_wr, dp_rd, rd_wait;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    uapl_tx_e tx_st;
    logic [CNT_W-1:0] tx_cnt;
    logic [3:0] tx_bit, bells;
    logic [7:0] tx_sh, tx_hold;
    logic txd, tx_full, paused, xoff_pend, xon_pend, xoff_sent;
    uapl_rx_e rx_st;
    logic [CNT_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh, rx_data, lost;
    logic rx_perr, rx_full;
  } uapl_st_s;

  localparam uapl_st_s ST_RST = '{rx_m: 1'b1, rx_s: 1'b1, char8: 1'b1,
    par: PAR_NONE, flow: FC_XON, bell: 1'b1, rx_rate: RST_RATE,
    tx_rate: RST_RATE, tx_st: T_IDLE, txd: 1'b1, rx_st: R_IDLE,
    default: '0};

  // the sixteen line rates in bits per second
  function automatic logic [15:0] rate_bps(input logic [3:0] i);
    case (i)
      4'h0: rate_bps = 16'd50;    4'h1: rate_bps = 16'd75;
      4'h2: rate_bps = 16'd110;   4'h3: rate_bps = 16'd134;
      4'h4: rate_bps = 16'd150;   4'h5: rate_bps = 16'd300;
      4'h6: rate_bps = 16'd600;   4'h7: rate_bps = 16'd1200;
      4'h8: rate_bps = 16'd1800;  4'h9: rate_bps = 16'd2000;
      4'hA: rate_bps = 16'd2400;  4'hB: rate_bps = 16'd4800;
      4'hC: rate_bps = 16'd7200;  4'hD: rate_bps = 16'd9600;
      4'hE: rate_bps = 16'd19200; default: rate_bps = 16'd38400;
    endcase
  endfunction

  // parity bit over 7 or 8 data bits
  function automatic logic par_bit(input logic [7:0] d, input logic c8,
                                   input logic odd);
    par_bit = (c8 ? ^d : ^d[6:0]) ^ odd;
  endfunction
endpackage

// ### design/uapl_port.sv
// serial port line, format, rates, flow control and bus registers
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module uapl_port
  import uapl_pkg::*;
#(
  parameter int CLK_HZ = 125_000_000  // clock rate, scales bit periods
)(
  input  wire logic           hclk,      // bus clock
  input  wire logic           hresetn,   // async reset, active low
  input  wire logic           hsel,      // slave select
  input  wire logic [31:0]    haddr,     // byte address
  input  wire logic [1:0]     htrans,    // transfer type
  input  wire logic           hwrite,    // write when high
  input  wire logic [2:0]     hsize,     // transfer size
  input  wire logic [31:0]    hwdata,    // write data
  input  wire logic           hready,    // bus ready in
  output logic [31:0]         hrdata,    // read data
  output logic                hreadyout, // slave ready
  output logic                hresp,     // always okay
  input  wire uapl_line_in_s  line_i,    // rxd, cts, dsr pins
  output uapl_line_out_s      line_o,    // txd, rts, dtr pins
  output logic                irq        // interrupt level
);

  uapl_st_s         st;
  uapl_st_s         next_st;
  logic             hunt;
  logic             locked;
  logic             c8;
  logic             can_tx;
  logic             deliver;
  logic             ferr;
  logic             lose;
  uapl_par_e        epar;
  logic [3:0]       nb;
  logic [3:0]       abd_idx;
  logic [3:0]       ev;
  logic [7:0]       rxc;
  logic [CNT_W-1:0] rx_per;
  logic [CNT_W-1:0] tx_per;
  logic [CNT_W-1:0] abd_per;
  logic [31:0]      rmux;

  // bit period in clock cycles for a rate index
  function automatic logic [CNT_W-1:0] per(input logic [3:0] i);
    per = CNT_W'(CLK_HZ / int'(rate_bps(i)));
  endfunction

  // slowest rate with three quarters of its period within a measured start bit
  function automatic logic [3:0] pick(input logic [CNT_W-1:0] w);
    logic [CNT_W+1:0] a;
    logic [CNT_W+1:0] b;
    logic [CNT_W-1:0] p;
    pick = 4'h0;
    a = {w, 2'b00};
    for (int i = 15; i >= 0; i--)
    begin
      p = per(4'(i));
      b = {2'b00, p} + {1'b0, p, 1'b0};
      if (a >= b)
        pick = 4'(i);
    end
  endfunction

  // next state of the whole port
  always_comb
  begin
    next_st = st;
    hunt    = st.abd & ~st.logged_in;
    locked  = hunt;
    c8      = st.char8 | hunt;
    epar    = hunt ? PAR_NONE : st.par;
    nb      = c8 ? 4'h8 : 4'h7;
    rx_per  = per(st.rx_rate);
    tx_per  = per(st.tx_rate);
    abd_idx = pick(st.rx_cnt);
    abd_per = per(abd_idx);
    rxc     = c8 ? st.rx_sh : {1'b0, st.rx_sh[7:1]};
    deliver = 1'b0;
    ferr    = 1'b0;
    lose    = 1'b0;
    ev      = 4'h0;
    rmux    = 32'h0;

    // two-flop synchronisers for the pins
    next_st.rx_m  = line_i.rxd;
    next_st.rx_s  = st.rx_m;
    next_st.cts_m = line_i.cts;
    next_st.cts_s = st.cts_m;
    next_st.dsr_m = line_i.dsr;
    next_st.dsr_s = st.dsr_m;

    // bus data phase of a write
    if (st.dp_wr)
    begin
      case (st.dp_addr)
        OFF_CTRL:
        begin
          next_st.abd  = hwdata[C_ABD];
          next_st.font = hwdata[C_FONT];
          next_st.bell = hwdata[C_BELL];
          if (hwdata[C_LOGOUT])
            next_st.logged_in = 1'b0;
          if (!locked)
          begin
            next_st.char8 = hwdata[C_CHAR8];
            next_st.par   = (hwdata[C_PAR+:2] == 2'b11) ? PAR_NONE
                          : uapl_par_e'(hwdata[C_PAR+:2]);
            next_st.flow  = uapl_flow_e'(hwdata[C_FLOW+:2]);
          end
        end
        OFF_RATE:
          if (!locked)
          begin
            next_st.rx_rate = hwdata[3:0];
            next_st.tx_rate = hwdata[R_BOTH] ? hwdata[3:0]
                            : hwdata[7:4];
          end
        OFF_TXD:
          if (!st.tx_full)
          begin
            next_st.tx_hold = hwdata[7:0];
            next_st.tx_full = 1'b1;
          end
        OFF_STS:  next_st.sts  = st.sts & ~hwdata[NSTS-1:0];
        OFF_MASK: next_st.mask = hwdata[NSTS-1:0];
        default:  next_st.mask = st.mask;
      endcase
    end

    // bus data phase of a read: one wait, then data
    next_st.dp_wr = 1'b0;
    if (st.dp_rd & ~st.rd_wait)
    begin
      next_st.rd_wait = 1'b1;
      case (st.dp_addr)
        OFF_CTRL: rmux = {24'h0, st.bell, st.font, st.abd, st.flow,
                          st.par, st.char8};
        OFF_RATE: rmux = {24'h0, st.tx_rate, st.rx_rate};
        OFF_TXD:  rmux = {31'h0, st.tx_full};
        OFF_RXD:
        begin
          rmux = {24'h0, st.rx_data};
          next_st.rx_full   = 1'b0;
          next_st.xoff_pend = 1'b0;
          if (st.xoff_sent)
          begin
            next_st.xon_pend  = 1'b1;
            next_st.xoff_sent = 1'b0;
          end
        end
        OFF_STS:  rmux = {28'h0, st.sts};
        OFF_MASK: rmux = {28'h0, st.mask};
        OFF_LINE: rmux = {16'h0, st.lost, 3'h0, st.rx_full, st.dsr_s,
                          st.cts_s, st.paused, st.logged_in};
        default:  rmux = 32'h0;
      endcase
      next_st.hrdata = rmux;
    end
    else if (st.rd_wait)
    begin
      next_st.dp_rd   = 1'b0;
      next_st.rd_wait = 1'b0;
    end

    // bus address phase
    if (hsel & hready & htrans[1])
    begin
      next_st.dp_addr = haddr[7:0];
      next_st.dp_wr   = hwrite & (hsize == 3'b010);
      next_st.dp_rd   = ~hwrite;
    end

    // transmitter
    can_tx = ~((st.flow == FC_XON) & st.paused)
           & ~((st.flow == FC_RTS) & ~st.cts_s)
           & ~((st.flow == FC_DTR) & ~st.dsr_s);
    if (st.tx_st != T_IDLE)
      next_st.tx_cnt = st.tx_cnt - 1'b1;
    unique case (st.tx_st)
      T_IDLE:
      begin
        next_st.tx_cnt = tx_per - 1'b1;
        next_st.tx_st  = T_START;
        if (st.xoff_pend)
        begin
          next_st.tx_sh     = CH_XOFF;
          next_st.xoff_pend = 1'b0;
          next_st.xoff_sent = 1'b1;
        end
        else if (st.xon_pend)
        begin
          next_st.tx_sh    = CH_XON;
          next_st.xon_pend = 1'b0;
        end
        else if (can_tx & (st.bells != 4'h0))
        begin
          next_st.tx_sh = CH_BELL;
          next_st.bells = st.bells - 4'h1;
        end
        else if (can_tx & st.tx_full)
        begin
          next_st.tx_sh   = st.tx_hold;
          next_st.tx_full = 1'b0;
          ev[S_TX]        = 1'b1;
        end
        else
          next_st.tx_st = T_IDLE;
      end
      T_START:
        if (st.tx_cnt == '0)
        begin
          next_st.tx_cnt = tx_per - 1'b1;
          next_st.tx_bit = 4'h0;
          next_st.tx_st  = T_DATA;
        end
      T_DATA:
        if (st.tx_cnt == '0)
        begin
          next_st.tx_cnt = tx_per - 1'b1;
          next_st.tx_bit = st.tx_bit + 4'h1;
          if (st.tx_bit == nb - 4'h1)
            next_st.tx_st = (epar == PAR_NONE) ? T_STOP : T_PAR;
        end
      T_PAR:
        if (st.tx_cnt == '0)
        begin
          next_st.tx_cnt = tx_per - 1'b1;
          next_st.tx_st  = T_STOP;
        end
      T_STOP:
        if (st.tx_cnt == '0)
          next_st.tx_st = T_IDLE;
    endcase

    // line level follows the frame state
    case (next_st.tx_st)
      T_START: next_st.txd = 1'b0;
      T_DATA:  next_st.txd = next_st.tx_sh[next_st.tx_bit[2:0]];
      T_PAR:   next_st.txd = par_bit(next_st.tx_sh, c8, epar == PAR_ODD);
      default: next_st.txd = 1'b1;
    endcase

    // receiver
    if (st.rx_st != R_IDLE)
      next_st.rx_cnt = st.rx_cnt - 1'b1;
    unique case (st.rx_st)
      R_IDLE:
        if (!st.rx_s)
        begin
          next_st.rx_cnt = hunt ? '0 : {1'b0, rx_per[CNT_W-1:1]};
          next_st.rx_st  = hunt ? R_MEAS : R_START;
        end
      R_MEAS:
      begin
        next_st.rx_cnt = (&st.rx_cnt) ? st.rx_cnt : st.rx_cnt + 1'b1;
        if (st.rx_s)
        begin
          next_st.rx_rate = abd_idx;
          next_st.tx_rate = abd_idx;
          next_st.rx_cnt  = {1'b0, abd_per[CNT_W-1:1]};
          next_st.rx_bit  = 4'h0;
          next_st.rx_perr = 1'b0;
          next_st.rx_st   = R_DATA;
        end
      end
      R_START:
        if (st.rx_cnt == '0)
        begin
          next_st.rx_cnt  = rx_per - 1'b1;
          next_st.rx_bit  = 4'h0;
          next_st.rx_perr = 1'b0;
          next_st.rx_st   = st.rx_s ? R_IDLE : R_DATA;
        end
      R_DATA:
        if (st.rx_cnt == '0)
        begin
          next_st.rx_sh  = {st.rx_s, st.rx_sh[7:1]};
          next_st.rx_cnt = rx_per - 1'b1;
          next_st.rx_bit = st.rx_bit + 4'h1;
          if (st.rx_bit == nb - 4'h1)
            next_st.rx_st = (epar == PAR_NONE) ? R_STOP : R_PAR;
        end
      R_PAR:
        if (st.rx_cnt == '0)
        begin
          next_st.rx_perr = st.rx_s
                          != par_bit(rxc, c8, epar == PAR_ODD);
          next_st.rx_cnt  = rx_per - 1'b1;
          next_st.rx_st   = R_STOP;
        end
      R_STOP:
        if (st.rx_cnt == '0)
        begin
          deliver       = 1'b1;
          ferr          = ~st.rx_s;
          next_st.rx_st = R_IDLE;
        end
      default: next_st.rx_st = R_IDLE;
    endcase

    // autobaud verdict on the login character
    if (deliver & hunt & ~ferr)
    begin
      if (st.rx_sh == CH_CR)
      begin
        next_st.char8     = 1'b1;
        next_st.par       = PAR_NONE;
        next_st.logged_in = 1'b1;
        ev[S_ABD]         = 1'b1;
      end
      else if (st.rx_sh == CH_CR7E)
      begin
        next_st.char8     = 1'b0;
        next_st.par       = PAR_EVEN;
        next_st.logged_in = 1'b1;
        ev[S_ABD]         = 1'b1;
      end
    end
    else if (deliver & ~hunt)
    begin
      if (ferr | st.rx_perr | next_st.rx_full)
        lose = 1'b1;
      else if ((st.flow == FC_XON) & (rxc == CH_XOFF))
        next_st.paused = st.paused | ~st.font;
      else if ((st.flow == FC_XON) & (rxc == CH_XON))
        next_st.paused = 1'b0;
      else
      begin
        next_st.rx_data = rxc;
        next_st.rx_full = 1'b1;
        ev[S_RX]        = 1'b1;
        if ((st.flow == FC_XON) & ~st.xoff_sent)
          next_st.xoff_pend = 1'b1;
      end
    end

    // lost characters are counted and answered with a bell
    if (lose)
    begin
      next_st.lost = st.lost + 8'h01;
      if (st.bell & (next_st.bells != 4'hF))
        next_st.bells = next_st.bells + 4'h1;
    end
    ev[S_LOST]  = lose;
    next_st.sts = next_st.sts | ev;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= ST_RST;
    else
      st <= next_st;
  end

  // outputs
  assign hrdata     = st.hrdata;
  assign hreadyout  = ~(st.dp_rd & ~st.rd_wait);
  assign hresp      = 1'b0;
  assign irq        = |(st.sts & st.mask);
  assign line_o.txd = st.txd;
  assign line_o.rts = ~((st.flow == FC_RTS) & st.rx_full);
  assign line_o.dtr = ~((st.flow == FC_DTR) & st.rx_full);

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_start_bit_low: assert property (
    st.tx_st == T_START |-> !line_o.txd)
    else $error("start bit not low");
  a_stop_bit_high: assert property (
    st.tx_st == T_STOP |-> line_o.txd)
    else $error("stop bit not high");
  a_rate_locked: assert property (
    locked && st.dp_wr && st.dp_addr == OFF_RATE && st.rx_st != R_MEAS
    |=> $stable(st.rx_rate) && $stable(st.tx_rate))
    else $error("rate changed while autobaud hunts");
  a_rate_both: assert property (
    !locked && st.dp_wr && st.dp_addr == OFF_RATE && hwdata[R_BOTH]
    && st.rx_st != R_MEAS |=> st.rx_rate == st.tx_rate)
    else $error("combined rate write split the rates");
  a_xoff_hold: assert property (
    st.flow == FC_XON && st.paused && st.tx_st == T_IDLE
    && !st.xoff_pend && !st.xon_pend |=> st.tx_st == T_IDLE)
    else $error("output sent while paused");
  a_cts_hold: assert property (
    st.flow == FC_RTS && !st.cts_s && st.tx_st == T_IDLE
    && !st.xoff_pend && !st.xon_pend |=> st.tx_st == T_IDLE)
    else $error("output sent while clear to send off");
  a_rts_drop: assert property (
    st.flow == FC_RTS && $rose(st.rx_full) |-> !line_o.rts)
    else $error("request to send kept with full buffer");
  a_lost_count: assert property (
    lose |=> st.lost == $past(st.lost) + 8'h01)
    else $error("lost character not counted");
  a_font_xoff: assert property (
    deliver && !hunt && !lose && st.font && st.flow == FC_XON
    && rxc == CH_XOFF && !st.paused |=> !st.paused)
    else $error("xoff obeyed in font loading");
  a_read_wait: assert property (
    st.dp_rd && !st.rd_wait |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_autobaud: cover property (ev[S_ABD]);
  c_lost:     cover property (lose && st.bell);
  c_tx_frame: cover property (st.tx_st == T_STOP ##1 st.tx_st == T_IDLE);
  c_paused:   cover property (st.paused && st.flow == FC_XON);

endmodule // uapl_port

// ### tb/uapl_term.sv
// serial terminal model at the far end of the port line
`timescale 1ns/10ps
module uapl_term
  import uapl_pkg::*;
(
  input  wire logic           hclk,   // bench clock
  input  wire uapl_line_out_s line_o, // port outputs
  output uapl_line_in_s       line_i  // port inputs
);
  int         per = 32; // bit period in cycles
  logic       c8  = 1;  // eight data bits
  logic [1:0] par = 0;  // parity code
  logic [7:0] got [$];  // characters received
  logic [7:0] d;
  logic       pe;
  initial line_i = '{rxd: 1'b1, cts: 1'b1, dsr: 1'b1};
  // set the handshake pins of the terminal
  task automatic pins(input logic c, input logic s);
    line_i.cts <= c;
    line_i.dsr <= s;
  endtask
  // send one frame; flip spoils the parity bit
  task automatic send(input logic [7:0] ch, input logic flip);
    line_i.rxd <= 1'b0;
    repeat (per) @(posedge hclk);
    for (int i = 0; i < (c8 ? 8 : 7); i++)
    begin
      line_i.rxd <= ch[i];
      repeat (per) @(posedge hclk);
    end
    if (par != 2'b00)
    begin
      line_i.rxd <= (c8 ? ^ch : ^ch[6:0]) ^ par[0] ^ flip;
      repeat (per) @(posedge hclk);
    end
    line_i.rxd <= 1'b1;
    repeat (per) @(posedge hclk);
  endtask
  // decode frames from the port at mid bit
  always
  begin
    @(negedge line_o.txd);
    repeat (per / 2) @(posedge hclk);
    d = 8'h00;
    pe = 1'b0;
    for (int i = 0; i < (c8 ? 8 : 7); i++)
    begin
      repeat (per) @(posedge hclk);
      d[i] = line_o.txd;
    end
    if (par != 2'b00)
    begin
      repeat (per) @(posedge hclk);
      pe = line_o.txd ^ (c8 ? ^d : ^d[6:0]) ^ par[0];
    end
    repeat (per) @(posedge hclk);
    if (line_o.txd === 1'b1 && !pe)
      got.push_back(d);
  end
endmodule // uapl_term

// ### tb/testbench.sv
// self-checking bench for the serial port block
`timescale 1ns/10ps
module testbench import uapl_pkg::*;;
  localparam int HZ = 1228800;
  logic           hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0]    haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]     htrans = 0;
  logic [2:0]     hsize = 0;
  logic           hreadyout, hresp, irq;
  uapl_line_in_s  line_i;
  uapl_line_out_s line_o;
  int             fails = 0, cmp_count = 0, seed = 32'h2f930cd9;
  logic [7:0]     ch;
  logic           rdy;
  logic [2:0]     fm [4] = '{3'b001, 3'b100, 3'b011, 3'b010};
  uapl_port #(.CLK_HZ(HZ)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .line_i(line_i), .line_o(line_o), .irq(irq));
  uapl_term term (.hclk(hclk), .line_o(line_o), .line_i(line_i));
  // clock
  always #4 hclk = ~hclk;
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // one single word bus transfer; ready and read data are looked at
  // on the falling edge, where they stand settled for the next rise
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do
    begin
      @(negedge hclk);
      rdy = hreadyout;
      @(posedge hclk);
    end
    while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do
    begin
      @(negedge hclk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end
    while (rdy !== 1'b1);
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // poll a status flag
  task automatic poll(input int b);
    for (int i = 0; i < 3000; i++)
    begin
      bus(1'b0, OFF_STS, 32'h0);
      if (rd[b] === 1'b1)
        break;
    end
    chk("status flag", 1, rd[b]);
  endtask
  // wait for a character at the terminal
  task automatic txe(input logic [7:0] e);
    for (int i = 0; i < 3000 && term.got.size() == 0; i++)
      @(posedge hclk);
    if (term.got.size() == 0)
      term.got.push_back(8'hXX);
    chk("tx char", e, term.got.pop_front());
  endtask
  // character as seen in the current width
  function automatic logic [7:0] fmt(input logic [7:0] c);
    return term.c8 ? c : {1'b0, c[6:0]};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("ctrl", OFF_CTRL, 32'h99);
    chk("hresp", 0, hresp);
    rchk("rate", OFF_RATE, 32'hDD);
    rchk("unmapped", 8'h1C, 32'h0);
    repeat (4)
    begin
      ch = $random(seed);
      bus(1'b1, OFF_RATE, {24'h0, ch});
      rchk("split rate", OFF_RATE, {24'h0, ch});
    end
    bus(1'b1, OFF_RATE, 32'h10E);
    rchk("both rates", OFF_RATE, 32'hEE);
    bus(1'b1, OFF_RATE, 32'h10F);
    for (int f = 0; f < 4; f++)
    begin
      term.c8 = fm[f][0];
      term.par = fm[f][2:1];
      bus(1'b1, OFF_CTRL, {24'h0, 5'h10, fm[f]});
      ch = $random(seed);
      bus(1'b1, OFF_TXD, {24'h0, ch});
      txe(fmt(ch));
      ch = $random(seed);
      term.send(ch, 1'b0);
      poll(S_RX);
      rchk("rx char", OFF_RXD, {24'h0, fmt(ch)});
      rchk("sts", OFF_STS, 32'h3);
      bus(1'b1, OFF_STS, 32'hF);
    end
    term.c8 = 1'b1;
    term.par = 2'b10;
    bus(1'b1, OFF_CTRL, 32'h85);
    term.send(8'h5A, 1'b0);
    term.send(8'hA5, 1'b1);
    txe(CH_BELL);
    term.send(8'h3C, 1'b0);
    txe(CH_BELL);
    rchk("lost", OFF_LINE, 32'h21C);
    chk("irq masked", 0, irq);
    bus(1'b1, OFF_MASK, 32'h4);
    repeat (2) @(posedge hclk);
    chk("irq", 1, irq);
    bus(1'b1, OFF_STS, 32'h4);
    repeat (2) @(posedge hclk);
    chk("irq clear", 0, irq);
    rchk("kept", OFF_RXD, 32'h5A);
    term.par = 2'b00;
    for (int m = 1; m < 3; m++)
    begin
      bus(1'b1, OFF_CTRL, {27'h0, m[1:0], 3'b001});
      term.send(8'h66, 1'b0);
      repeat (40) @(posedge hclk);
      chk("hs full", {m != 1, m != 2}, {line_o.rts, line_o.dtr});
      rchk("hs rx", OFF_RXD, 32'h66);
      repeat (3) @(posedge hclk);
      chk("hs free", 2'b11, {line_o.rts, line_o.dtr});
      term.pins(m != 1, m != 2);
      bus(1'b1, OFF_TXD, 32'h3A);
      repeat (300) @(posedge hclk);
      chk("hs held", 0, term.got.size());
      rchk("tx held", OFF_TXD, 32'h1);
      term.pins(1'b1, 1'b1);
      txe(8'h3A);
    end
    bus(1'b1, OFF_CTRL, 32'h19);
    term.send(CH_XOFF, 1'b0);
    bus(1'b1, OFF_TXD, 32'h4B);
    repeat (400) @(posedge hclk);
    rchk("paused", OFF_LINE, 32'h20E);
    chk("xoff held", 0, term.got.size());
    term.send(CH_XON, 1'b0);
    txe(8'h4B);
    term.send(8'h21, 1'b0);
    txe(CH_XOFF);
    rchk("xon rx", OFF_RXD, 32'h21);
    txe(CH_XON);
    bus(1'b1, OFF_CTRL, 32'h59);
    term.send(CH_XOFF, 1'b0);
    rchk("font", OFF_LINE, 32'h20C);
    bus(1'b1, OFF_CTRL, 32'h01);
    bus(1'b1, OFF_CTRL, 32'h21);
    bus(1'b1, OFF_RATE, 32'h77);
    rchk("locked", OFF_RATE, 32'hFF);
    term.per = HZ / 19200;
    term.send(CH_CR, 1'b0);
    poll(S_ABD);
    rchk("abd rate", OFF_RATE, 32'hEE);
    bus(1'b1, OFF_CTRL, 32'h121);
    bus(1'b1, OFF_STS, 32'hF);
    term.per = HZ / 9600;
    term.c8 = 1'b0;
    term.par = 2'b10;
    term.send(CH_CR, 1'b0);
    poll(S_ABD);
    rchk("abd fmt", OFF_CTRL, 32'h24);
    rchk("abd rate2", OFF_RATE, 32'hDD);
    test_done;
  end
  // cut a hang short
  initial
  begin
    repeat (90000) @(posedge hclk);
    fails++;
    test_done;
  end
endmodule // testbench
